// [hw/ssr_pkg.sv]
// constants and register map for the sensor status and result registers
//
// Operation
// R1: while a new mode is still crossing into the core domain the done flag reads 0 and mode register access is blocked.
// R2: once the crossing completes the done flag reads 1 and mode register access is allowed again.
// R3: the dynamic bus address register returns the currently assigned address in all eight bits.
// R4: the revision byte holds the major number in bits 7:4 and the minor number in bits 3:0.
// R5: pressure result bits 7:0 and 15:8 appear in the low and middle pressure registers.
// R6: pressure result bits 19:16 sit in the low nibble of the high pressure register, upper nibble reserved.
// R7: temperature result bits 7:0 and 15:8 appear in the low and middle temperature registers.
// R8: temperature result bits 19:16 sit in the low nibble of the high temperature register, upper nibble reserved.
// R9: the host polls the done flag for 1 before rewriting the mode register and ignores reserved bits.
package ssr_pkg;

	// register offsets
	localparam logic [7:0] CHIP_CONDITION_ADDR         = 8'hCD;
	localparam logic [7:0] DYNAMIC_BUS_ADDRESS_ADDR    = 8'hCE;
	localparam logic [7:0] SILICON_REVISION_ADDR       = 8'hD3;
	localparam logic [7:0] BAROMETRIC_SAMPLE_LOW_ADDR  = 8'hFA;
	localparam logic [7:0] BAROMETRIC_SAMPLE_MID_ADDR  = 8'hFB;
	localparam logic [7:0] BAROMETRIC_SAMPLE_HIGH_ADDR = 8'hFC;
	localparam logic [7:0] THERMAL_SAMPLE_LOW_ADDR     = 8'hFD;
	localparam logic [7:0] THERMAL_SAMPLE_MID_ADDR     = 8'hFE;
	localparam logic [7:0] THERMAL_SAMPLE_HIGH_ADDR    = 8'hFF;

	// reset values and fill
	localparam logic [7:0]  BYTE_RESET   = 8'h00;
	localparam logic [19:0] SAMPLE_RESET = 20'h00000;
	localparam logic [3:0]  NIBBLE_ZERO  = 4'h0;
	localparam logic [6:0]  COND_FILL    = 7'h00;
	localparam logic [7:0]  UNMAPPED_RD  = 8'h00;

	// field positions inside a 20-bit result
	localparam int LOW_LSB = 0;
	localparam int LOW_MSB = 7;
	localparam int MID_LSB = 8;
	localparam int MID_MSB = 15;
	localparam int TOP_LSB = 16;
	localparam int TOP_MSB = 19;

	// single-bit levels
	localparam logic FLAG_CLEAR = 1'h0;
	localparam logic FLAG_SET   = 1'h1;

	// revision values, arbitrary neutral defaults
	localparam logic [3:0] REV_MAJOR_DEF = 4'h1;
	localparam logic [3:0] REV_MINOR_DEF = 4'h0;

endpackage : ssr_pkg

// [hw/ssr_regs.sv]
// read-only status and result register bank of the sensor
`timescale 1ns/1ps
module ssr_regs #(
	parameter logic [3:0] REV_MAJOR = ssr_pkg::REV_MAJOR_DEF, // arbitrary
	parameter logic [3:0] REV_MINOR = ssr_pkg::REV_MINOR_DEF  // arbitrary
) (
	input  wire logic        sys_clk_i,     // 40 MHz system clock
	input  wire logic        rst_i,         // sync reset, active high
	input  wire logic        rd_en_i,       // register read strobe
	input  wire logic [7:0]  rd_addr_i,     // register read address
	input  wire logic        mode_busy_i,   // mode crossing in progress
	input  wire logic [7:0]  dyn_addr_i,    // assigned dynamic address
	input  wire logic        sample_vld_i,  // new results strobe
	input  wire logic [19:0] press_i,       // pressure result
	input  wire logic [19:0] temp_i,        // temperature result
	output logic [7:0]       rd_data_o,     // read data, one cycle later
	output logic             rd_vld_o,      // read data valid pulse
	output logic             mode_acc_o     // mode register accessible
);

	// status bytes
	logic        mode_done_ff;   // handoff finished
	logic        nxt_mode_done;  // flag taken at the next edge
	logic [7:0]  dyn_addr_ff;    // last seen dynamic address
	logic [7:0]  nxt_dyn_addr;   // address taken at the next edge

	// result bytes, all loaded on the same strobe
	logic [7:0]  press_low_ff;   // pressure bits 7:0
	logic [7:0]  press_mid_ff;   // pressure bits 15:8
	logic [3:0]  press_top_ff;   // pressure bits 19:16
	logic [7:0]  temp_low_ff;    // temperature bits 7:0
	logic [7:0]  temp_mid_ff;    // temperature bits 15:8
	logic [3:0]  temp_top_ff;    // temperature bits 19:16

	// offset decode, one hit per register
	logic        hit_cond;
	logic        hit_dyn;
	logic        hit_rev;
	logic        hit_press_low;
	logic        hit_press_mid;
	logic        hit_press_top;
	logic        hit_temp_low;
	logic        hit_temp_mid;
	logic        hit_temp_top;

	// gated read terms, zero unless their register is hit
	logic [7:0]  term_cond;
	logic [7:0]  term_dyn;
	logic [7:0]  term_rev;
	logic [7:0]  term_press_low;
	logic [7:0]  term_press_mid;
	logic [7:0]  term_press_top;
	logic [7:0]  term_temp_low;
	logic [7:0]  term_temp_mid;
	logic [7:0]  term_temp_top;

	// read path
	logic [7:0]  nxt_rd_data;    // byte for the next answer
	logic        nxt_rd_vld;     // answer due next cycle

	////////////////////////////////////////////////////////////////////////
	// handoff flag: clears while busy, sets when the crossing finishes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode_done_ff <= ssr_pkg::FLAG_CLEAR;
		end else begin
			mode_done_ff <= nxt_mode_done; // R1 R2
		end
	end

	// done only once the crossing status has dropped
	always_comb begin
		nxt_mode_done = ~mode_busy_i; // R1 R2
	end

	// access gate mirrors the flag so both agree every cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mode_acc_o <= ssr_pkg::FLAG_CLEAR;
		end else begin
			mode_acc_o <= nxt_mode_done; // R1 R2
		end
	end

	// dynamic address tracked each cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dyn_addr_ff <= ssr_pkg::BYTE_RESET;
		end else begin
			dyn_addr_ff <= nxt_dyn_addr; // R3
		end
	end

	// address passes whole, all eight bits
	always_comb begin
		nxt_dyn_addr = dyn_addr_i; // R3
	end

	////////////////////////////////////////////////////////////////////////
	// pressure low byte; one strobe for all so every byte holds the same sample, though separate reads can span a strobe
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			press_low_ff <= ssr_pkg::BYTE_RESET;
		end else if (sample_vld_i) begin
			press_low_ff <=
				press_i[ssr_pkg::LOW_MSB:ssr_pkg::LOW_LSB]; // R5
		end
	end

	// pressure middle byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			press_mid_ff <= ssr_pkg::BYTE_RESET;
		end else if (sample_vld_i) begin
			press_mid_ff <=
				press_i[ssr_pkg::MID_MSB:ssr_pkg::MID_LSB]; // R5
		end
	end

	// pressure top nibble
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			press_top_ff <= ssr_pkg::NIBBLE_ZERO;
		end else if (sample_vld_i) begin
			press_top_ff <=
				press_i[ssr_pkg::TOP_MSB:ssr_pkg::TOP_LSB]; // R6
		end
	end

	// temperature low byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			temp_low_ff <= ssr_pkg::BYTE_RESET;
		end else if (sample_vld_i) begin
			temp_low_ff <=
				temp_i[ssr_pkg::LOW_MSB:ssr_pkg::LOW_LSB]; // R7
		end
	end

	// temperature middle byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			temp_mid_ff <= ssr_pkg::BYTE_RESET;
		end else if (sample_vld_i) begin
			temp_mid_ff <=
				temp_i[ssr_pkg::MID_MSB:ssr_pkg::MID_LSB]; // R7
		end
	end

	// temperature top nibble
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			temp_top_ff <= ssr_pkg::NIBBLE_ZERO;
		end else if (sample_vld_i) begin
			temp_top_ff <=
				temp_i[ssr_pkg::TOP_MSB:ssr_pkg::TOP_LSB]; // R8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// offset decode; unmapped offsets leave every hit clear
	always_comb begin
		hit_cond      = ssr_pkg::FLAG_CLEAR;
		hit_dyn       = ssr_pkg::FLAG_CLEAR;
		hit_rev       = ssr_pkg::FLAG_CLEAR;
		hit_press_low = ssr_pkg::FLAG_CLEAR;
		hit_press_mid = ssr_pkg::FLAG_CLEAR;
		hit_press_top = ssr_pkg::FLAG_CLEAR;
		hit_temp_low  = ssr_pkg::FLAG_CLEAR;
		hit_temp_mid  = ssr_pkg::FLAG_CLEAR;
		hit_temp_top  = ssr_pkg::FLAG_CLEAR;
		// offsets all differ, so the hits stay one-hot
		case (rd_addr_i)
			ssr_pkg::CHIP_CONDITION_ADDR: begin
				hit_cond = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::DYNAMIC_BUS_ADDRESS_ADDR: begin
				hit_dyn = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::SILICON_REVISION_ADDR: begin
				hit_rev = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::BAROMETRIC_SAMPLE_LOW_ADDR: begin
				hit_press_low = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::BAROMETRIC_SAMPLE_MID_ADDR: begin
				hit_press_mid = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::BAROMETRIC_SAMPLE_HIGH_ADDR: begin
				hit_press_top = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::THERMAL_SAMPLE_LOW_ADDR: begin
				hit_temp_low = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::THERMAL_SAMPLE_MID_ADDR: begin
				hit_temp_mid = ssr_pkg::FLAG_SET;
			end
			ssr_pkg::THERMAL_SAMPLE_HIGH_ADDR: begin
				hit_temp_top = ssr_pkg::FLAG_SET;
			end
			default: begin
				hit_cond = ssr_pkg::FLAG_CLEAR; // unmapped reads zero
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// condition byte, flag in bit 0 and the rest reserved
	always_comb begin
		term_cond = ssr_pkg::UNMAPPED_RD;
		if (hit_cond) begin
			term_cond = {ssr_pkg::COND_FILL, mode_done_ff}; // R1 R2
		end
	end

	// dynamic address byte
	always_comb begin
		term_dyn = ssr_pkg::UNMAPPED_RD;
		if (hit_dyn) begin
			term_dyn = dyn_addr_ff; // R3
		end
	end

	// revision byte, major over minor
	always_comb begin
		term_rev = ssr_pkg::UNMAPPED_RD;
		if (hit_rev) begin
			term_rev = {REV_MAJOR, REV_MINOR}; // R4
		end
	end

	// pressure low byte
	always_comb begin
		term_press_low = ssr_pkg::UNMAPPED_RD;
		if (hit_press_low) begin
			term_press_low = press_low_ff; // R5
		end
	end

	// pressure middle byte
	always_comb begin
		term_press_mid = ssr_pkg::UNMAPPED_RD;
		if (hit_press_mid) begin
			term_press_mid = press_mid_ff; // R5
		end
	end

	// pressure top nibble, reserved upper half reads zero
	always_comb begin
		term_press_top = ssr_pkg::UNMAPPED_RD;
		if (hit_press_top) begin
			term_press_top = {ssr_pkg::NIBBLE_ZERO, press_top_ff}; // R6
		end
	end

	// temperature low byte
	always_comb begin
		term_temp_low = ssr_pkg::UNMAPPED_RD;
		if (hit_temp_low) begin
			term_temp_low = temp_low_ff; // R7
		end
	end

	// temperature middle byte
	always_comb begin
		term_temp_mid = ssr_pkg::UNMAPPED_RD;
		if (hit_temp_mid) begin
			term_temp_mid = temp_mid_ff; // R7
		end
	end

	// temperature top nibble, reserved upper half reads zero
	always_comb begin
		term_temp_top = ssr_pkg::UNMAPPED_RD;
		if (hit_temp_top) begin
			term_temp_top = {ssr_pkg::NIBBLE_ZERO, temp_top_ff}; // R8
		end
	end

	// or of the gated terms; flat and cheap since hits are one-hot
	always_comb begin
		nxt_rd_data = term_cond | term_dyn | term_rev
			| term_press_low | term_press_mid | term_press_top
			| term_temp_low | term_temp_mid | term_temp_top;
	end

	////////////////////////////////////////////////////////////////////////
	// every request is answered, nothing is refused
	always_comb begin
		nxt_rd_vld = rd_en_i;
	end

	// valid pulse, one cycle after the request
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_vld_o <= ssr_pkg::FLAG_CLEAR;
		end else begin
			rd_vld_o <= nxt_rd_vld;
		end
	end

	// data holds between reads so a slow host can still take it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_data_o <= ssr_pkg::BYTE_RESET;
		end else if (nxt_rd_vld) begin
			rd_data_o <= nxt_rd_data;
		end
	end

endmodule : ssr_regs

// [test/sensor_status_result_regs_tb.sv]
// self-checking bench for the status and result registers
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, a, e); end end
module sensor_status_result_regs_tb;
	logic clk = 0, rst = 1, busy = 1, sv = 0, ok;
	logic [7:0] dyn = 8'h5A, d, ra;
	logic [19:0] pr = 20'hABCDE, tp = 20'h13579;
	logic [7:0] ea[6] = '{8'hDE, 8'hBC, 8'h0A, 8'h79, 8'h35, 8'h01};
	logic re, vl, acc;
	logic [7:0] rdat;
	int n_errors = 0, cmp_count = 0;
	always #12.5 clk = ~clk;
	ssr_regs dut (.sys_clk_i(clk), .rst_i(rst), .rd_en_i(re), .rd_addr_i(ra),
		.mode_busy_i(busy), .dyn_addr_i(dyn), .sample_vld_i(sv), .press_i(pr),
		.temp_i(tp), .rd_data_o(rdat), .rd_vld_o(vl), .mode_acc_o(acc));
	ssr_host host (.clk_i(clk), .rd_vld_i(vl), .rd_data_i(rdat),
		.rd_en_o(re), .rd_addr_o(ra));
	task finish_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// watchdog, tests need about 36 cycles
	initial begin #20000 n_errors++; finish_test; end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		host.rd(8'hFA, d); `CHK(d, 8'h00)
		host.rd(8'hCD, d); `CHK(d, 8'h00)
		`CHK(acc, 1'b0)
		busy = 0;
		host.poll(ok); `CHK(ok, 1'b1)
		`CHK(acc, 1'b1)
		host.rd(8'hCE, d); `CHK(d, dyn)
		host.rd(8'hD3, d); `CHK(d, {ssr_pkg::REV_MAJOR_DEF, ssr_pkg::REV_MINOR_DEF})
		$display("status tests done");
		@(posedge clk) #1 sv = 1;
		@(posedge clk) #1 sv = 0;
		foreach (ea[i]) begin host.rd(8'hFA + 8'(i), d); `CHK(d, ea[i]) end
		$display("result tests done");
		finish_test;
	end
endmodule : sensor_status_result_regs_tb

// [test/ssr_host.sv]
// host model issuing single register reads
`timescale 1ns/1ps
module ssr_host (
	input  wire logic       clk_i,     // system clock
	input  wire logic       rd_vld_i,  // read answer valid
	input  wire logic [7:0] rd_data_i, // read answer
	output logic            rd_en_o,   // read strobe
	output logic [7:0]      rd_addr_o  // read offset
);
	initial begin
		rd_en_o = 1'b0;
		rd_addr_o = 8'h00;
	end
	// one-cycle strobe, address inverted once released
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i) #1 rd_en_o = 1'b1;
		rd_addr_o = a;
		@(posedge clk_i) #1 rd_en_o = 1'b0;
		rd_addr_o = ~a;
		d = rd_vld_i ? rd_data_i : 8'hXX;
	endtask : rd
	// bounded wait for the handoff flag before touching the mode
	task poll(output logic ok);
		logic [7:0] v;
		ok = 1'b0;
		repeat (8) if (!ok) begin rd(8'hCD, v); ok = v[0]; end
	endtask : poll
endmodule : ssr_host

// [test/ssr_regs_sva.sv]
// assertions on the status and result register ports
`timescale 1ns/1ps
module ssr_regs_sva #(parameter logic [3:0] REV_MAJOR = 4'h1,
	parameter logic [3:0] REV_MINOR = 4'h0) (
	input wire logic sys_clk_i, rst_i, rd_en_i, mode_busy_i, sample_vld_i,
	input wire logic rd_vld_o, mode_acc_o, // design answers
	input wire logic [7:0] rd_addr_i, dyn_addr_i, rd_data_o, // bytes
	input wire logic [19:0] press_i, temp_i); // results
	logic [19:0] p_ff, t_ff;
	wire rq = rd_en_i && !sample_vld_i;
	// shadow of the captured results, reads on a capture edge skipped
	always_ff @(posedge sys_clk_i) begin
		p_ff <= rst_i ? 20'h00000 : sample_vld_i ? press_i : p_ff;
		t_ff <= rst_i ? 20'h00000 : sample_vld_i ? temp_i : t_ff;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	a_busy_blocks: assert property (mode_busy_i |=> !mode_acc_o)
		else $error("mode access while busy");
	a_done_opens: assert property (!mode_busy_i |=> mode_acc_o)
		else $error("mode access missing");
	a_flag_read: assert property (rd_en_i && !$past(rst_i) &&
		rd_addr_i == 8'hCD |=> rd_vld_o &&
		rd_data_o == {7'h00, !$past(mode_busy_i, 2)})
		else $error("done flag wrong");
	a_addr_read: assert property (rd_en_i && !$past(rst_i) &&
		rd_addr_i == 8'hCE |=> rd_vld_o &&
		rd_data_o == $past(dyn_addr_i, 2)) else $error("address wrong");
	a_press_low: assert property (rq && rd_addr_i == 8'hFA |=>
		rd_data_o == p_ff[7:0]) else $error("pressure low wrong");
	a_temp_mid: assert property (rq && rd_addr_i == 8'hFE |=>
		rd_data_o == t_ff[15:8]) else $error("temperature mid wrong");
	a_rev_read: assert property (rd_en_i && rd_addr_i == 8'hD3 |=>
		rd_data_o == {REV_MAJOR, REV_MINOR}) else $error("revision wrong");
	a_press_mid: assert property (rq && rd_addr_i == 8'hFB |=>
		rd_data_o == p_ff[15:8]) else $error("pressure mid wrong");
	a_press_top: assert property (rq && rd_addr_i == 8'hFC |=>
		rd_data_o == {4'h0, p_ff[19:16]}) else $error("pressure top wrong");
	a_temp_low: assert property (rq && rd_addr_i == 8'hFD |=>
		rd_data_o == t_ff[7:0]) else $error("temperature low wrong");
	a_temp_top: assert property (rq && rd_addr_i == 8'hFF |=>
		rd_data_o == {4'h0, t_ff[19:16]}) else $error("temperature top wrong");
endmodule : ssr_regs_sva
bind ssr_regs ssr_regs_sva #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR))
	u_sva (.*);
